// ### bench/can_bus_node.sv
`timescale 1ns/1ns
// far side of the receive pin: other nodes and the bit timing that samples them
module can_bus_node (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // bench control
  input  wire logic bits_on,
  input  wire logic dominant,
  // toward the status block
  output      logic rx_pin,
  output      logic rx_sample_strobe
);
  logic [1:0] phase;

  // one sample point every four clocks; the strobe stands still when no bits flow
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      phase <= 2'h0;
    else
      phase <= bits_on ? phase + 2'h1 : 2'h0;
  end

  // the bus idles recessive (high) while dominant is low
  assign rx_sample_strobe = bits_on && (phase == 2'h3);
  assign rx_pin           = ~dominant;
endmodule : can_bus_node

// ### bench/can_status_regs_bench.sv
`timescale 1ns/1ns
module can_status_regs_bench;
  logic                             mclk     = 1'b0;
  logic                             reset_n  = 1'b0;
  logic [11:0]                      paddr    = 12'h000;
  logic                             psel     = 1'b0;
  logic                             penable  = 1'b0;
  logic                             pwrite   = 1'b0;
  logic [31:0]                      pwdata   = 32'h00000000;
  logic [5:0]                       evt      = 6'h00;
  logic [5:0][2:0]                  mbe      = '0;
  can_status_pkg::can_id_type [2:0] mb_id    = {11'h411, 11'h433, 11'h400};
  logic                             bits_on  = 1'b0;
  logic                             dominant = 1'b0;
  logic [31:0]                      prdata;
  logic                             pready;
  logic                             pslverr;
  logic                             rx_pin;
  logic                             rx_sample_strobe;
  logic [2:0]                       mb_pending;
  logic [2:0]                       mb_cancel;
  logic                             sleep_ack;
  logic                             freeze_ack;
  logic                             status_change_irq;
  logic [31:0]                      rdat;
  logic                             perr;
  int                               n_errors = 0;
  int                               compares = 0;

  always #20 mclk = ~mclk;

  // short recessive run keeps the mode exits quick
  can_status_regs #(.RECESSIVE_BITS(3)) dut_u (
    .mclk(mclk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .rx_sample_strobe(rx_sample_strobe), .rx_frame_start(evt[0]), .rx_frame_end(evt[1]),
    .tx_frame_start(evt[2]), .tx_frame_end(evt[3]), .sof_seen(evt[4]), .error_status_set(evt[5]),
    .mb_request(mbe[0]), .mb_tx_start(mbe[1]), .mb_tx_ok(mbe[2]), .mb_arb_lost(mbe[3]),
    .mb_tx_err(mbe[4]), .mb_abort_done(mbe[5]), .mb_id(mb_id), .mb_pending(mb_pending),
    .mb_cancel(mb_cancel), .sleep_ack(sleep_ack), .freeze_ack(freeze_ack),
    .status_change_irq(status_change_irq));

  can_bus_node node_u (.mclk(mclk), .reset_n(reset_n), .bits_on(bits_on), .dominant(dominant),
    .rx_pin(rx_pin), .rx_sample_strobe(rx_sample_strobe));

  task stop_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task check32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check32

  task check1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check1

  // apb transfer; the request is held until pready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 40) begin
        n_errors++;
        stop_test();
      end
      @(posedge mclk);
    end
    rdat = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check32(rdat & m, exp);
  endtask : rd_chk

  // a bounded wait for an acknowledge level; running out counts as a mismatch
  task wait_ack(input logic fz, input logic v);
    int n;
    n = 0;
    while ((fz ? freeze_ack : sleep_ack) !== v) begin
      n++;
      if (n > 200) begin
        n_errors++;
        stop_test();
      end
      @(posedge mclk);
    end
  endtask : wait_ack

  task fire(input logic [5:0] e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= 6'h00;
  endtask : fire

  task fire_mb(input int k, input logic [2:0] m);
    @(posedge mclk);
    mbe[k] <= m;
    @(posedge mclk);
    mbe[k] <= 3'h0;
  endtask : fire_mb

  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    bits_on <= 1'b1;
    rd_chk(12'h000, 32'hFFFFFFFF, 32'h00000002);
    check1(perr, 1'b0);
    rd_chk(12'h004, 32'hFFFFFFFF, 32'h00000C02);
    rd_chk(12'h008, 32'hFFFFFFFF, 32'h1C000000);
    rd_chk(12'h00C, 32'hFFFFFFFF, 32'h00000000);
    check1(perr, 1'b1);
    apb(1'b1, 12'h004, 32'hFFFFFFFF);
    rd_chk(12'h004, 32'hFFFFFFFF, 32'h00000C02);
    // leave sleep, then enter it again with the entry flag enabled
    apb(1'b1, 12'h014, 32'h00000003);
    apb(1'b1, 12'h000, 32'h00000000);
    wait_ack(1'b0, 1'b0);
    rd_chk(12'h004, 32'hFFFFFFFF, 32'h00000C00);
    apb(1'b1, 12'h000, 32'h00000002);
    rd_chk(12'h004, 32'hFFFFFFFF, 32'h00000C12);
    check1(status_change_irq, 1'b1);
    fire(6'h10);
    wait_ack(1'b0, 1'b0);
    rd_chk(12'h004, 32'hFFFFFFFF, 32'h00000C08);
    apb(1'b1, 12'h004, 32'h00000008);
    rd_chk(12'h004, 32'hFFFFFFFF, 32'h00000C00);
    check1(status_change_irq, 1'b0);
    // dominant bits pull both pin levels low
    dominant <= 1'b1;
    repeat (10) @(posedge mclk);
    rd_chk(12'h004, 32'h00000C00, 32'h00000000);
    dominant <= 1'b0;
    // freeze requested while frames are in flight must wait for them
    fire(6'h05);
    rd_chk(12'h004, 32'h00000300, 32'h00000300);
    apb(1'b1, 12'h000, 32'h00000001);
    repeat (4) @(posedge mclk);
    check1(freeze_ack, 1'b0);
    fire(6'h0A);
    wait_ack(1'b1, 1'b1);
    rd_chk(12'h004, 32'hFFFFFFFF, 32'h00000C01);
    apb(1'b1, 12'h000, 32'h00000000);
    wait_ack(1'b1, 1'b0);
    // error flag needs its source enable
    apb(1'b1, 12'h014, 32'h00000004);
    fire(6'h20);
    rd_chk(12'h004, 32'h00000004, 32'h00000000);
    apb(1'b1, 12'h014, 32'h0000000C);
    fire(6'h20);
    rd_chk(12'h004, 32'h00000004, 32'h00000004);
    check1(status_change_irq, 1'b1);
    apb(1'b1, 12'h004, 32'h00000004);
    rd_chk(12'h004, 32'h00000004, 32'h00000000);
    // mailboxes: fill, fail, cancel, finish
    fire_mb(0, 3'b001);
    rd_chk(12'h008, 32'hFFFFFFFF, 32'h19000000);
    fire_mb(0, 3'b110);
    rd_chk(12'h008, 32'hFFFFFFFF, 32'h41000000);
    check32({29'h0, mb_pending}, 32'h00000007);
    fire_mb(3, 3'b100);
    fire_mb(4, 3'b100);
    rd_chk(12'h008, 32'hFFFFFFFF, 32'h410C0000);
    fire_mb(1, 3'b100);
    rd_chk(12'h008, 32'hFFFFFFFF, 32'h41000000);
    fire_mb(3, 3'b100);
    apb(1'b1, 12'h008, 32'h00800000);
    // the cancel bit is loaded at the write edge, so look one edge later
    @(posedge mclk);
    check1(mb_cancel[2], 1'b1);
    fire_mb(5, 3'b100);
    rd_chk(12'h008, 32'hFFFFFFFF, 32'h52050000);
    check1(mb_cancel[2], 1'b0);
    apb(1'b1, 12'h008, 32'h00010000);
    rd_chk(12'h008, 32'hFFFFFFFF, 32'h52000000);
    fire_mb(4, 3'b010);
    fire_mb(2, 3'b010);
    rd_chk(12'h008, 32'hFFFFFFFF, 32'h19000B00);
    apb(1'b1, 12'h008, 32'h00008100);
    @(posedge mclk);
    check1(mb_cancel[1], 1'b0);
    rd_chk(12'h008, 32'hFFFFFFFF, 32'h19000000);
    fire_mb(3, 3'b001);
    fire_mb(0, 3'b100);
    fire_mb(2, 3'b100);
    rd_chk(12'h008, 32'hFFFFFFFF, 32'h19030004);
    // partial reset puts the sleep request back and the block goes to sleep
    apb(1'b1, 12'h000, 32'h00008000);
    wait_ack(1'b0, 1'b1);
    rd_chk(12'h000, 32'hFFFFFFFF, 32'h00000002);
    stop_test();
  end
endmodule : can_status_regs_bench

// ### logic/can_status_cfg.svh
`ifndef CAN_STATUS_CFG_SVH
`define CAN_STATUS_CFG_SVH
// register byte offsets
`define OFF_CTRL       12'h000
`define OFF_MSTS       12'h004
`define OFF_TSTS       12'h008
`define OFF_INTEN      12'h014
// control word fields
`define CTRL_FREEZE    0
`define CTRL_SLEEP     1
`define CTRL_PRST      15
`define CTRL_RESET     32'h00000002
// interrupt enable word fields
`define IE_ENTRY       0
`define IE_EXIT        1
`define IE_ERROR       2
`define IE_ERR_SRC     3
`define INTEN_RESET    4'h0
// master status fields
`define MS_LIVE        11
`define MS_SAMP        10
`define MS_RXACT       9
`define MS_TXACT       8
`define MS_ENTRY       4
`define MS_EXIT        3
`define MS_ERR         2
`define MS_SLEEP       1
`define MS_FREEZE      0
// transmit status fields, per mailbox at stride 8
`define TS_STRIDE      8
`define TS_TCF         0
`define TS_TSF         1
`define TS_ALF         2
`define TS_TEF         3
`define TS_CT          7
// recessive bits needed to leave sleep or freeze
`define RECESSIVE_RUN  11
`endif

// ### logic/can_status_pkg.sv
package can_status_pkg;
  typedef enum logic [2:0] {
    st_run         = 3'h0,
    st_sleep       = 3'h1,
    st_sleep_exit  = 3'h2,
    st_freeze      = 3'h3,
    st_freeze_exit = 3'h4
  } mode_type;
  typedef logic [10:0] can_id_type;
endpackage : can_status_pkg

// ### logic/can_status_regs.sv
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "can_status_cfg.svh"
module can_status_regs #(
  parameter int RECESSIVE_BITS = `RECESSIVE_RUN
) (
  // clock and reset
  input  wire logic                             mclk,
  input  wire logic                             reset_n,
  // apb slave
  input  wire logic [11:0]                      paddr,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [31:0]                      pwdata,
  output      logic [31:0]                      prdata,
  output      logic                             pready,
  output      logic                             pslverr,
  // bus pin and protocol engine events
  input  wire logic                             rx_pin,
  input  wire logic                             rx_sample_strobe,
  input  wire logic                             rx_frame_start,
  input  wire logic                             rx_frame_end,
  input  wire logic                             tx_frame_start,
  input  wire logic                             tx_frame_end,
  input  wire logic                             sof_seen,
  input  wire logic                             error_status_set,
  // mailbox events from the transmit engine
  input  wire logic [2:0]                       mb_request,
  input  wire logic [2:0]                       mb_tx_start,
  input  wire logic [2:0]                       mb_tx_ok,
  input  wire logic [2:0]                       mb_arb_lost,
  input  wire logic [2:0]                       mb_tx_err,
  input  wire logic [2:0]                       mb_abort_done,
  input  wire can_status_pkg::can_id_type [2:0] mb_id,
  // state toward the engine
  output      logic [2:0]                       mb_pending,
  output      logic [2:0]                       mb_cancel,
  output      logic                             sleep_ack,
  output      logic                             freeze_ack,
  output      logic                             status_change_irq
);
  if (RECESSIVE_BITS < 1 || RECESSIVE_BITS > 15) begin : g_bad_run
    $error("RECESSIVE_BITS must lie in 1..15");
  end

  // largest identifier loses arbitration; ties go to the higher index
  function automatic logic [1:0] lowest_prio(input logic [2:0] pend,
                                             input can_status_pkg::can_id_type [2:0] id);
    logic [1:0] best;
    logic       found;
    best  = 2'h0;
    found = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (pend[i] && (!found || id[i] >= id[best])) begin
        best  = 2'(i);
        found = 1'b1;
      end
    end
    return best;
  endfunction : lowest_prio

  can_status_pkg::mode_type state;
  can_status_pkg::mode_type next_state;
  logic        sleep_request;
  logic        freeze_request;
  logic [3:0]  inten;
  logic        rx_pin_live_level;
  logic        rx_pin_sampled_level;
  logic        receive_active;
  logic        transmit_active;
  logic        sleep_entry_flag;
  logic        sleep_exit_flag;
  logic        error_irq_flag;
  logic [3:0]  recessive_count;
  logic [2:0]  mb_done, mb_ok, mb_arb, mb_err;

  // apb decode; the slave never waits
  wire access    = psel & penable;
  wire setup     = psel & ~penable;
  wire wr        = access & pwrite;
  wire hit_ctrl  = paddr == `OFF_CTRL;
  wire hit_msts  = paddr == `OFF_MSTS;
  wire hit_tsts  = paddr == `OFF_TSTS;
  wire hit_inten = paddr == `OFF_INTEN;
  wire unmapped  = ~(hit_ctrl | hit_msts | hit_tsts | hit_inten);
  wire wr_ctrl   = wr & hit_ctrl;
  wire wr_msts   = wr & hit_msts;
  wire wr_tsts   = wr & hit_tsts;
  wire wr_inten  = wr & hit_inten;
  wire prst      = wr_ctrl & pwdata[`CTRL_PRST];
  assign pready  = access;
  assign pslverr = access & unmapped;

  // mode handling
  wire idle       = ~receive_active & ~transmit_active;
  wire run_seen   = recessive_count >= 4'(RECESSIVE_BITS);
  wire wake       = (state == can_status_pkg::st_sleep) & sof_seen;
  wire enter_slp  = (state != can_status_pkg::st_sleep) & (next_state == can_status_pkg::st_sleep);
  wire leave_slp  = (state == can_status_pkg::st_sleep_exit) & (next_state == can_status_pkg::st_run);
  wire exiting    = (state == can_status_pkg::st_sleep_exit) | (state == can_status_pkg::st_freeze_exit);
  wire next_sleep_ack  = (next_state == can_status_pkg::st_sleep) |
                         (next_state == can_status_pkg::st_sleep_exit);
  wire next_freeze_ack = (next_state == can_status_pkg::st_freeze) |
                         (next_state == can_status_pkg::st_freeze_exit);

  // a mode is only entered between frames
  always_comb begin
    next_state = state;
    unique case (state)
      can_status_pkg::st_run: begin
        if (sleep_request && idle) begin
          next_state = can_status_pkg::st_sleep;
        end else if (freeze_request && idle) begin
          next_state = can_status_pkg::st_freeze;
        end
      end
      can_status_pkg::st_sleep: begin
        if (!sleep_request) begin
          next_state = can_status_pkg::st_sleep_exit;
        end
      end
      can_status_pkg::st_sleep_exit: begin
        if (run_seen) begin
          next_state = can_status_pkg::st_run;
        end
      end
      can_status_pkg::st_freeze: begin
        if (!freeze_request) begin
          next_state = can_status_pkg::st_freeze_exit;
        end
      end
      can_status_pkg::st_freeze_exit: begin
        if (run_seen) begin
          next_state = can_status_pkg::st_run;
        end
      end
      default: next_state = can_status_pkg::st_run;
    endcase
  end

  // reset parks the block asleep with the request standing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= can_status_pkg::st_sleep;
      sleep_ack  <= 1'b1;
      freeze_ack <= 1'b0;
    end else begin
      state      <= next_state;
      sleep_ack  <= next_sleep_ack;
      freeze_ack <= next_freeze_ack;
    end
  end

  // control requests; partial reset forces sleep back on
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_request  <= 1'(`CTRL_RESET >> `CTRL_SLEEP);
      freeze_request <= 1'b0;
    end else if (prst) begin
      sleep_request  <= 1'b1;
      freeze_request <= 1'b0;
    end else if (wake) begin
      sleep_request  <= 1'b0;
    end else if (wr_ctrl) begin
      sleep_request  <= pwdata[`CTRL_SLEEP];
      freeze_request <= pwdata[`CTRL_FREEZE];
    end
  end

  // interrupt enables
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      inten <= `INTEN_RESET;
    end else if (wr_inten) begin
      inten <= pwdata[3:0];
    end
  end

  // recessive run counter restarts whenever an exit begins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      recessive_count <= 4'h0;
    end else if (!exiting) begin
      recessive_count <= 4'h0;
    end else if (rx_sample_strobe) begin
      recessive_count <= !rx_pin ? 4'h0 : run_seen ? recessive_count : recessive_count + 4'h1;
    end
  end

  // pin levels and bus activity
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_pin_live_level    <= 1'b1;
      rx_pin_sampled_level <= 1'b1;
      receive_active       <= 1'b0;
      transmit_active      <= 1'b0;
    end else begin
      rx_pin_live_level    <= rx_pin;
      rx_pin_sampled_level <= rx_sample_strobe ? rx_pin : rx_pin_sampled_level;
      receive_active       <= rx_frame_start | (receive_active & ~rx_frame_end);
      transmit_active      <= tx_frame_start | (transmit_active & ~tx_frame_end);
    end
  end

  // status change flags; a set in the clearing cycle survives
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_entry_flag  <= 1'b0;
      sleep_exit_flag   <= 1'b0;
      error_irq_flag    <= 1'b0;
      status_change_irq <= 1'b0;
    end else begin
      sleep_entry_flag  <= (enter_slp & inten[`IE_ENTRY]) |
                           (sleep_entry_flag & ~(wr_msts & pwdata[`MS_ENTRY]) & ~leave_slp);
      sleep_exit_flag   <= wake | (sleep_exit_flag & ~(wr_msts & pwdata[`MS_EXIT]));
      error_irq_flag    <= (error_status_set & inten[`IE_ERR_SRC]) |
                           (error_irq_flag & ~(wr_msts & pwdata[`MS_ERR]));
      status_change_irq <= (sleep_entry_flag & inten[`IE_ENTRY]) |
                           (sleep_exit_flag & inten[`IE_EXIT]) |
                           (error_irq_flag & inten[`IE_ERROR]);
    end
  end

  // transmit mailboxes; status bytes share one layout
  wire [7:0] mb_byte [3];
  for (genvar i = 0; i < 3; i++) begin : g_mb
    mbox_if mbi ();
    assign mbi.request    = mb_request[i];
    assign mbi.tx_start   = mb_tx_start[i];
    assign mbi.tx_ok      = mb_tx_ok[i];
    assign mbi.arb_lost   = mb_arb_lost[i];
    assign mbi.tx_err     = mb_tx_err[i];
    assign mbi.abort_done = mb_abort_done[i];
    assign mbi.clr_done   = wr_tsts & pwdata[`TS_STRIDE*i + `TS_TCF];
    assign mbi.clr_ok     = wr_tsts & pwdata[`TS_STRIDE*i + `TS_TSF];
    assign mbi.clr_arb    = wr_tsts & pwdata[`TS_STRIDE*i + `TS_ALF];
    assign mbi.clr_err    = wr_tsts & pwdata[`TS_STRIDE*i + `TS_TEF];
    assign mbi.set_cancel = wr_tsts & pwdata[`TS_STRIDE*i + `TS_CT];
    assign mb_pending[i]  = mbi.pending;
    assign mb_cancel[i]   = mbi.cancel;
    assign mb_done[i]     = mbi.done;
    assign mb_ok[i]       = mbi.ok;
    assign mb_arb[i]      = mbi.arb;
    assign mb_err[i]      = mbi.err;
    assign mb_byte[i]     = {mb_cancel[i], 3'h0, mb_err[i], mb_arb[i], mb_ok[i], mb_done[i]};
    tx_mailbox_flags u_flags (
      .mclk    (mclk),
      .reset_n (reset_n),
      .mb      (mbi.flags)
    );
  end

  // priority, empty and hint decode
  wire [2:0] mb_empty  = ~mb_pending;
  wire       several   = (mb_pending[0] & mb_pending[1]) | (mb_pending[0] & mb_pending[2]) |
                         (mb_pending[1] & mb_pending[2]);
  wire [1:0] low_idx   = lowest_prio(mb_pending, mb_id);
  wire [2:0] mb_lowest = several ? 3'(3'h1 << low_idx) : 3'h0;
  wire [1:0] free_idx  = mb_empty[0] ? 2'h0 : mb_empty[1] ? 2'h1 : 2'h2;
  wire [1:0] mailbox_index_hint = (|mb_empty) ? free_idx : low_idx;

  // read words; reserved positions read zero
  wire [31:0] msts_word = {20'h00000, rx_pin_live_level, rx_pin_sampled_level, receive_active,
                           transmit_active, 3'h0, sleep_entry_flag, sleep_exit_flag,
                           error_irq_flag, sleep_ack, freeze_ack};
  wire [31:0] tsts_word = {mb_lowest, mb_empty, mailbox_index_hint, mb_byte[2], mb_byte[1], mb_byte[0]};
  wire [31:0] ctrl_word = {30'h00000000, sleep_request, freeze_request};
  wire [31:0] read_word = hit_ctrl  ? ctrl_word :
                          hit_msts  ? msts_word :
                          hit_tsts  ? tsts_word :
                          hit_inten ? {28'h0000000, inten} : 32'h00000000;

  // read data is captured in the setup cycle, so it stands through access
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : read_word;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // mode, flag and pin checks; mailbox flags are watched inside their own module
  a_live_level: assert property (rx_pin_live_level == $past(rx_pin))
    else $error("live pin level not following the pin");
  a_exit_flag_set: assert property (wake |=> sleep_exit_flag)
    else $error("wake did not set the exit flag");
  a_prst_sleep: assert property (prst |=> sleep_request && !freeze_request)
    else $error("partial reset did not restore the sleep request");
  a_entry_irq: assert property (sleep_entry_flag && inten[`IE_ENTRY] |=> status_change_irq)
    else $error("sleep entry flag raised no interrupt");
  a_sleep_entry_idle: assert property ($rose(sleep_ack) |-> $past(idle))
    else $error("sleep acknowledged during bus activity");
  a_sleep_exit_run: assert property ($fell(sleep_ack) |-> $past(run_seen))
    else $error("sleep left without a recessive run");
  a_freeze_exit_run: assert property ($fell(freeze_ack) |-> $past(run_seen) && $past(exiting))
    else $error("freeze left without a recessive run");
  a_rx_active_set: assert property (rx_frame_start |=> receive_active)
    else $error("reception start not reported");
  a_tx_active_clear: assert property (tx_frame_end && !tx_frame_start |=> !transmit_active)
    else $error("transmit activity stuck after end");
  a_entry_flag_gate: assert property ($rose(sleep_entry_flag) |-> $past(inten[`IE_ENTRY]) && sleep_ack)
    else $error("sleep entry flag set without enable");
  a_error_flag_set: assert property (error_status_set && inten[`IE_ERR_SRC] |=> error_irq_flag)
    else $error("error flag not set");
  a_sampled_level: assert property (rx_sample_strobe |=> rx_pin_sampled_level == $past(rx_pin))
    else $error("sampled level not refreshed");
  a_hint_free: assert property (|mb_empty |-> mb_empty[mailbox_index_hint])
    else $error("hint does not point at a free mailbox");
  a_wake_clears_req: assert property (wake && !prst |=> !sleep_request ##1 state == can_status_pkg::st_sleep_exit)
    else $error("start of frame did not wake");

  c_sleep_round: cover property (sleep_ack ##[1:50] !sleep_ack);
  c_freeze_round: cover property ($rose(freeze_ack) ##[1:200] $fell(freeze_ack));
  c_all_full: cover property (mb_pending == 3'h7);
  c_irq: cover property ($rose(status_change_irq));
endmodule : can_status_regs

// ### logic/mbox_if.sv
`timescale 1ns/1ns
interface mbox_if;
  logic request, tx_start, tx_ok, arb_lost, tx_err, abort_done;
  logic clr_done, clr_ok, clr_arb, clr_err, set_cancel;
  logic pending, cancel, done, ok, arb, err;
  modport ctrl  (output request, tx_start, tx_ok, arb_lost, tx_err, abort_done,
                 output clr_done, clr_ok, clr_arb, clr_err, set_cancel,
                 input  pending, cancel, done, ok, arb, err);
  modport flags (input  request, tx_start, tx_ok, arb_lost, tx_err, abort_done,
                 input  clr_done, clr_ok, clr_arb, clr_err, set_cancel,
                 output pending, cancel, done, ok, arb, err);
endinterface : mbox_if

// ### logic/tx_mailbox_flags.sv
`timescale 1ns/1ns
module tx_mailbox_flags (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // mailbox events and status
  mbox_if.flags    mb
);
  logic pending, cancel, done, ok, arb, err;
  // a new request also retires the previous completion
  wire clear_done = mb.clr_done | mb.request;
  wire finish     = mb.tx_ok | mb.abort_done;

  // every set term wins over its clear term, except set_cancel, which finish clears in the same cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pending <= 1'b0;
      cancel  <= 1'b0;
      done    <= 1'b0;
      ok      <= 1'b0;
      arb     <= 1'b0;
      err     <= 1'b0;
    end else begin
      pending <= mb.request | (pending & ~finish);
      cancel  <= (mb.set_cancel | cancel) & pending & ~finish;
      done    <= finish | (done & ~clear_done);
      ok      <= mb.tx_ok | (ok & ~mb.clr_ok & ~clear_done);
      arb     <= mb.arb_lost | (arb & ~(mb.clr_arb | mb.tx_start | clear_done));
      err     <= mb.tx_err | (err & ~(mb.clr_err | mb.tx_start | clear_done));
    end
  end

  assign mb.pending = pending;
  assign mb.cancel  = cancel;
  assign mb.done    = done;
  assign mb.ok      = ok;
  assign mb.arb     = arb;
  assign mb.err     = err;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_cancel_when_free: assert property (mb.set_cancel && !pending && !cancel |=> !cancel)
    else $error("cancel accepted on a free mailbox");
  a_done_clears_all: assert property (mb.clr_done && !mb.tx_ok && !mb.arb_lost && !mb.tx_err
    |=> !ok && !arb && !err)
    else $error("clearing completion left result flags set");
  c_abort_done: cover property (cancel ##[1:20] done);
endmodule : tx_mailbox_flags
